// ==== rtl/fesps_seq.sv ====
// Flash write sequencer: erase, erase suspend, program in suspend, resume, protection set.
// Assumes control register writes arrive as one-cycle strobes with full 16-bit values.
`timescale 1ns/100ps
module fesps_seq (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_ce,
    input  wire logic        i_ctrl0_wr,
    input  wire logic [15:0] i_ctrl0_wdata,
    input  wire logic        i_ctrl1_wr,
    input  wire logic [15:0] i_ctrl1_wdata,
    input  wire logic        i_addr_low_wr,
    input  wire logic        i_addr_high_wr,
    input  wire logic        i_data0_low_wr,
    input  wire logic        i_data0_high_wr,
    input  wire logic [15:0] i_wdata,
    output logic [15:0]      o_ctrl0_high_reg,
    output logic [15:0]      o_ctrl1_high_reg,
    output logic [15:0]      o_addr_low_reg,
    output logic [15:0]      o_addr_high_reg,
    output logic [15:0]      o_data0_low_reg,
    output logic [15:0]      o_data0_high_reg,
    output logic [15:0]      o_nv_write_protect_inner_low,
    output logic             o_busy,
    output logic             o_erase_suspended,
    output logic             o_flash_erase_en,
    output logic             o_flash_prog_en,
    output logic [15:0]      o_erase_sectors,
    output logic             o_op_done
);
    import fesps_pkg::*;
    fesps_state_t state_reg;
    fesps_state_t state_next;
    logic [15:0]  ctrl0_reg;
    logic [15:0]  ctrl0_next;
    logic [15:0]  ctrl1_reg;
    logic [15:0]  addr_lo_reg;
    logic [15:0]  addr_hi_reg;
    logic [15:0]  data_lo_reg;
    logic [15:0]  data_hi_reg;
    logic [15:0]  nvwp_reg;
    logic [15:0]  erase_sec_reg;
    logic         done_reg;
    logic         timer_done;
    logic         timer_load;
    logic [CNT_W-1:0] timer_count;
    // Decoded requests
    wire hold_now   = ctrl0_reg[CTL_HOLD_BIT];
    wire start_req  = i_ctrl0_wr && i_ctrl0_wdata[CTL_START_BIT] && !ctrl0_reg[CTL_START_BIT];
    wire start_ok   = start_req && !hold_now;
    wire sel_ser    = i_ctrl0_wdata[CTL_SER_BIT];
    wire sel_wpg    = i_ctrl0_wdata[CTL_WPG_BIT];
    wire sel_prot   = i_ctrl0_wdata[CTL_PROT_BIT];
    wire hold_req   = i_ctrl0_wr && i_ctrl0_wdata[CTL_HOLD_BIT];
    wire prot_hit   = (addr_lo_reg == NVWP_INNER_LOW_ADDR_LO)
                   && (addr_hi_reg == NVWP_INNER_LOW_ADDR_HI);
    wire in_prog    = (state_reg == FESPS_PROGRAM);
    wire in_erase   = (state_reg == FESPS_ERASE);
    wire in_held    = (state_reg == FESPS_HELD);
    wire busy       = in_erase || in_prog || (state_reg == FESPS_PROTECT);
    // Separate program timer keeps the held erase count intact
    logic         erase_done;
    logic         prog_done;
    wire          erase_load = timer_load && (state_next == FESPS_ERASE);
    wire          prog_load  = (state_next == FESPS_PROGRAM || state_next == FESPS_PROTECT)
                            && (state_reg != state_next);
    assign timer_done = in_erase ? erase_done : prog_done;
    // Sequencer next state
    always_comb begin
        state_next  = state_reg;
        timer_load  = 1'b0;
        timer_count = '0;
        case (state_reg)
            FESPS_IDLE: begin
                if (start_ok && sel_ser) begin
                    state_next  = FESPS_ERASE;
                    timer_load  = 1'b1;
                    timer_count = CNT_W'(ERASE_CYCLES);
                end else if (start_ok && sel_wpg) begin
                    state_next  = FESPS_PROGRAM;
                    timer_load  = 1'b1;
                    timer_count = CNT_W'(PROGRAM_CYCLES);
                end else if (start_ok && sel_prot) begin
                    state_next  = FESPS_PROTECT;
                    timer_load  = 1'b1;
                    timer_count = CNT_W'(PROGRAM_CYCLES);
                end
            end
            FESPS_ERASE: begin
                if (hold_req) begin
                    state_next = FESPS_HELD;
                end else if (timer_done) begin
                    state_next = FESPS_IDLE;
                end
            end
            FESPS_HELD: begin
                if (start_ok && sel_ser) begin
                    state_next = FESPS_ERASE;
                end else if (start_ok && sel_wpg) begin
                    state_next = FESPS_PROGRAM;
                end
            end
            FESPS_PROGRAM: begin
                if (timer_done) begin
                    state_next = erase_sec_reg != '0 ? FESPS_HELD : FESPS_IDLE;
                end
            end
            FESPS_PROTECT: begin
                if (timer_done) begin
                    state_next = FESPS_IDLE;
                end
            end
            default: begin
                state_next = FESPS_IDLE;
            end
        endcase
    end
    // Control register 0: start is owned by the sequencer; hold and SER bits written while in program are forced low
    always_comb begin
        ctrl0_next = ctrl0_reg;
        if (i_ctrl0_wr && !(start_req && hold_now)) begin
            ctrl0_next = i_ctrl0_wdata;
            ctrl0_next[CTL_START_BIT] = start_ok || (busy && ctrl0_reg[CTL_START_BIT]);
            if (in_prog) begin
                ctrl0_next[CTL_HOLD_BIT] = 1'b0;
                ctrl0_next[CTL_SER_BIT]  = 1'b0;
            end
        end
        if (state_next == FESPS_IDLE || state_next == FESPS_HELD) begin
            ctrl0_next[CTL_START_BIT] = 1'b0;
        end
    end
    // Inner protection word update; zero bits protect sectors
    wire prot_commit = (state_reg == FESPS_PROTECT) && timer_done && prot_hit
                    && !ctrl0_reg[CTL_TFLASH_BIT];
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            nvwp_reg <= NVWP_RESET;
        end else if (i_ce && prot_commit) begin
            nvwp_reg <= nvwp_reg & data_lo_reg;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg     <= FESPS_IDLE;
            ctrl0_reg     <= CTL_RESET;
            ctrl1_reg     <= CTL_RESET;
            addr_lo_reg   <= ADDR_RESET;
            addr_hi_reg   <= ADDR_RESET;
            data_lo_reg   <= DATA_RESET;
            data_hi_reg   <= DATA_RESET;
            erase_sec_reg <= CTL_RESET;
            done_reg      <= 1'b0;
        end else if (i_ce) begin
            state_reg <= state_next;
            ctrl0_reg <= ctrl0_next;
            done_reg  <= timer_done && !in_held;
            if (i_ctrl1_wr && !busy) begin
                ctrl1_reg <= i_ctrl1_wdata;
            end
            if (i_addr_low_wr && !busy) begin
                addr_lo_reg <= i_wdata;
            end
            if (i_addr_high_wr && !busy) begin
                addr_hi_reg <= i_wdata;
            end
            if (i_data0_low_wr && !busy) begin
                data_lo_reg <= i_wdata;
            end
            if (i_data0_high_wr && !busy) begin
                data_hi_reg <= i_wdata;
            end
            if (in_erase && timer_done) begin
                erase_sec_reg <= '0;
            end else if (state_reg == FESPS_IDLE && state_next == FESPS_ERASE) begin
                erase_sec_reg <= ctrl1_reg;
            end
        end
    end
    fesps_timer u_timer (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .i_load    (erase_load),
        .i_count   (timer_count),
        .i_hold    (!in_erase),
        .o_done    (erase_done)
    );
    fesps_timer u_prog_timer (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .i_load    (prog_load),
        .i_count   (CNT_W'(PROGRAM_CYCLES)),
        .i_hold    (1'b0),
        .o_done    (prog_done)
    );
    assign o_ctrl0_high_reg             = ctrl0_reg;
    assign o_ctrl1_high_reg             = ctrl1_reg;
    assign o_addr_low_reg               = addr_lo_reg;
    assign o_addr_high_reg              = addr_hi_reg;
    assign o_data0_low_reg              = data_lo_reg;
    assign o_data0_high_reg             = data_hi_reg;
    assign o_nv_write_protect_inner_low = nvwp_reg;
    assign o_busy                       = busy;
    assign o_erase_suspended            = in_held || in_prog && (erase_sec_reg != '0);
    assign o_flash_erase_en             = in_erase;
    assign o_flash_prog_en              = in_prog || (state_reg == FESPS_PROTECT);
    assign o_erase_sectors              = erase_sec_reg;
    assign o_op_done                    = done_reg;
endmodule

// ==== rtl/fesps_pkg.sv ====
// Package for the flash erase-suspend-program sequencer.
// Assumes a single 100 MHz system clock and active-low asynchronous reset.
package fesps_pkg;
    // Control register 0 high bit positions
    localparam int CTL_START_BIT   = 15;
    localparam int CTL_HOLD_BIT    = 14;
    localparam int CTL_WPG_BIT     = 13;
    localparam int CTL_SER_BIT     = 11;
    localparam int CTL_PROT_BIT    = 8;
    localparam int CTL_WIDTH_BIT   = 4;
    localparam int CTL_TFLASH_BIT  = 3;
    localparam logic [15:0] CTL_RESET      = 16'h0000;
    localparam logic [15:0] ADDR_RESET     = 16'h0000;
    localparam logic [15:0] DATA_RESET     = 16'h0000;
    // Protection register location in the address space
    localparam logic [15:0] NVWP_INNER_LOW_ADDR_LO = 16'hDFB4;
    localparam logic [15:0] NVWP_INNER_LOW_ADDR_HI = 16'h000E;
    localparam logic [15:0] NVWP_RESET             = 16'hFFFF;
    // Operation times in ns and derived cycle counts
    localparam int CLK_PERIOD_NS    = 10;
    localparam int ERASE_TIME_NS    = 2000;
    localparam int PROGRAM_TIME_NS  = 400;
    localparam int ERASE_CYCLES     = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROGRAM_CYCLES   = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W            = 16;
    typedef enum logic [4:0] {
        FESPS_IDLE    = 5'b00001,
        FESPS_ERASE   = 5'b00010,
        FESPS_HELD    = 5'b00100,
        FESPS_PROGRAM = 5'b01000,
        FESPS_PROTECT = 5'b10000
    } fesps_state_t;
endpackage

// ==== rtl/fesps_timer.sv ====
// Busy timer that counts an operation down to completion.
// Assumes load and hold are synchronous to the system clock.
`timescale 1ns/100ps
module fesps_timer (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_resetn,
    input  wire logic                       i_ce,
    input  wire logic                       i_load,
    input  wire logic [fesps_pkg::CNT_W-1:0] i_count,
    input  wire logic                       i_hold,
    output logic                            o_done
);
    import fesps_pkg::*;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    wire              running = (cnt_reg != '0);
    // Count keeps its value while held, so a suspended erase resumes where it stopped
    assign cnt_next = i_load ? i_count :
                      (running && !i_hold) ? cnt_reg - 1'b1 : cnt_reg;
    assign o_done   = (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1}) && !i_hold && !i_load;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_reg <= '0;
        end else if (i_ce) begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

// ==== sim/fesps_seq_assertions.sv ====
// Port checker for the flash erase-suspend-program sequencer.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
module fesps_seq_assertions (
    input wire logic        i_clk_sys,
    input wire logic        i_resetn,
    input wire logic        i_ce,
    input wire logic        i_ctrl0_wr,
    input wire logic [15:0] i_ctrl0_wdata,
    input wire logic [15:0] o_ctrl0_high_reg,
    input wire logic [15:0] o_addr_low_reg,
    input wire logic [15:0] o_addr_high_reg,
    input wire logic [15:0] o_nv_write_protect_inner_low,
    input wire logic        o_busy,
    input wire logic        o_erase_suspended,
    input wire logic        o_flash_erase_en,
    input wire logic        o_flash_prog_en,
    input wire logic        o_op_done
);
    import fesps_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    wire logic wr_c0 = i_ce && i_ctrl0_wr;
    wire logic go_ok = wr_c0 && i_ctrl0_wdata[15] && !i_ctrl0_wdata[14] && !o_ctrl0_high_reg[14] && !o_busy;
    a_start_busy:
        assert property (go_ok && (i_ctrl0_wdata[11] || i_ctrl0_wdata[13] || i_ctrl0_wdata[8]) |=> o_busy)
        else $error("start not taken");
    a_held_start_dropped:
        assert property (wr_c0 && i_ctrl0_wdata[15] && o_ctrl0_high_reg[14] && !o_busy
            |=> $stable(o_ctrl0_high_reg) && !o_busy) else $error("start with hold bit not dropped");
    a_hold_suspends:
        assert property (o_flash_erase_en && !o_erase_suspended && wr_c0 && i_ctrl0_wdata[14]
            |=> o_erase_suspended && !o_flash_erase_en) else $error("erase not suspended");
    a_prog_bits_low:
        assert property (o_flash_prog_en && o_erase_suspended |-> !o_ctrl0_high_reg[11] && !o_ctrl0_high_reg[14])
        else $error("select bits high in suspended program");
    a_prog_runs_through:
        assert property ($rose(o_flash_prog_en) |-> o_flash_prog_en[*8] ##[25:45] o_op_done)
        else $error("program length wrong");
    a_done_idle:
        assert property (o_op_done |=> !o_op_done && !o_busy && !o_ctrl0_high_reg[15])
        else $error("done not followed by idle");
    a_resume_erase:
        assert property (o_erase_suspended && !o_busy && !o_ctrl0_high_reg[14] && wr_c0
            && i_ctrl0_wdata == 16'h8800 |=> o_flash_erase_en && !o_erase_suspended) else $error("erase not resumed");
    a_protect_commit:
        assert property ($changed(o_nv_write_protect_inner_low) |-> $past(o_addr_high_reg) == NVWP_INNER_LOW_ADDR_HI
            && $past(o_addr_low_reg) == NVWP_INNER_LOW_ADDR_LO && !$past(o_ctrl0_high_reg[3])
            && (o_nv_write_protect_inner_low & ~$past(o_nv_write_protect_inner_low)) == 16'h0000)
        else $error("protection word changed wrongly");
endmodule
bind fesps_seq fesps_seq_assertions u_chk (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_ctrl0_wr(i_ctrl0_wr), .i_ctrl0_wdata(i_ctrl0_wdata), .o_ctrl0_high_reg(o_ctrl0_high_reg),
    .o_addr_low_reg(o_addr_low_reg), .o_addr_high_reg(o_addr_high_reg),
    .o_nv_write_protect_inner_low(o_nv_write_protect_inner_low), .o_busy(o_busy),
    .o_erase_suspended(o_erase_suspended), .o_flash_erase_en(o_flash_erase_en),
    .o_flash_prog_en(o_flash_prog_en), .o_op_done(o_op_done));

// ==== sim/fesps_seq_bench.sv ====
// Testbench for the flash erase-suspend-program sequencer.
// Assumes the package, design and checker files are compiled first.
`timescale 1ns/100ps
module fesps_seq_bench;
    import fesps_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [5:0]  wv = 6'h00;
    logic [15:0] wd = 16'h0000;
    logic        busy, erase_hold_bit, er_en, pg_en, done;
    logic [15:0] c0, c1, al, ah, dl, dh, nvwp, sect;
    logic [15:0] obs [0:5];
    wire  [15:0] st = {12'h000, busy, erase_hold_bit, er_en, pg_en};
    logic [15:0] rv [0:5] = '{16'h0800, 16'h0002, 16'h5554, 16'h000C, 16'hAAAA, 16'h5555};
    int          failures = 0;
    int          check_count = 0;
    int          cyc = 0;
    fesps_seq DUT (.i_clk_sys(clk), .i_resetn(rstn), .i_ce(1'b1), .i_ctrl0_wr(wv[0]), .i_ctrl0_wdata(wd),
        .i_ctrl1_wr(wv[1]), .i_ctrl1_wdata(wd), .i_addr_low_wr(wv[2]), .i_addr_high_wr(wv[3]),
        .i_data0_low_wr(wv[4]), .i_data0_high_wr(wv[5]), .i_wdata(wd), .o_ctrl0_high_reg(c0),
        .o_ctrl1_high_reg(c1), .o_addr_low_reg(al), .o_addr_high_reg(ah), .o_data0_low_reg(dl),
        .o_data0_high_reg(dh), .o_nv_write_protect_inner_low(nvwp), .o_busy(busy),
        .o_erase_suspended(erase_hold_bit), .o_flash_erase_en(er_en), .o_flash_prog_en(pg_en),
        .o_erase_sectors(sect), .o_op_done(done));
    assign obs = '{c0, c1, al, ah, dl, dh};
    always #5 clk = ~clk;
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // One write strobe per call; outputs are settled on return
    task automatic wr(input int s, input logic [15:0] d);
        @(posedge clk);
        wv <= 6'h01 << s;
        wd <= d;
        @(posedge clk);
        wv <= 6'h00;
        #1;
    endtask
    task automatic wait_done();
        for (int k = 0; k < 400; k++) begin
            @(posedge clk);
            #1;
            if (done === 1'b1) begin
                break;
            end
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("protect word", 16'hFFFF, nvwp);
        chk("control 0", 16'h0000, c0);
        $display("Test reset finished");
        for (int i = 0; i < 6; i++) begin
            wr(i, rv[i]);
            chk("register", rv[i], obs[i]);
        end
        $display("Test table finished");
        wr(0, 16'h8800);
        chk("erase run", 16'h000A, st);
        chk("erase sectors", 16'h0002, sect);
        wr(0, 16'h4800);
        chk("erase held", 16'h0004, st);
        wr(0, 16'hC800);
        chk("held start", 16'h4800, c0);
        chk("held state", 16'h0004, st);
        $display("Test suspend finished");
        wr(0, 16'h0000);
        wr(0, 16'h2010);
        wr(0, 16'hA010);
        chk("program run", 16'h000D, st);
        chk("program selects", 16'h0000, c0 & 16'h4800);
        wr(0, 16'hE010);
        chk("hold in program", 16'h000D, st);
        chk("hold bit", 16'h0000, c0 & 16'h4800);
        wait_done();
        chk("back to held", 16'h0004, st);
        wr(0, 16'h0800);
        wr(0, 16'h8800);
        chk("resumed", 16'h000A, st);
        wait_done();
        chk("erase end", 16'h0000, st);
        chk("start clear", 16'h0000, c0 & 16'h8000);
        $display("Test resume finished");
        wr(2, 16'hDFB4);
        wr(3, 16'h000E);
        wr(4, 16'hFFF0);
        wr(5, 16'hFFFF);
        wr(0, 16'h0108);
        wr(0, 16'h8108);
        wait_done();
        chk("test-flash protect", 16'hFFFF, nvwp);
        wr(0, 16'h0100);
        wr(0, 16'h8100);
        chk("protect run", 16'h0009, st);
        wait_done();
        chk("protect word", 16'hFFF0, nvwp);
        $display("Test protect finished");
        finish_test();
    end
endmodule
